// ==== core/cmoc_mode_ctrl.sv ====
// Operating mode controller of the CAN module, with pin and lock logic.
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/1ns
module cmoc_mode_ctrl (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] modeRequest,
  input wire logic cfgWe,
  input wire logic [2:0] cfgAddr,
  input wire logic [15:0] cfgWdata,
  output logic [15:0] cfgRdata,
  output logic cfgRefused,
  output logic [15:0] controlWord,
  input wire logic sleepMode,
  input wire logic busRxPin,
  output logic busTxOut,
  output logic busTxOe_n,
  output logic txPinOwned,
  output logic rxPinOwned,
  input wire logic coreTx,
  output logic coreRx,
  input wire logic txActive,
  input wire logic frameError,
  input wire logic txRequestSet,
  output logic txRequestFlag,
  output logic txAbortedFlag,
  input wire logic txAbortedClear,
  output logic txStart,
  output logic wakeFlag,
  input wire logic wakeClear,
  output logic txEnable,
  output logic rxEnable,
  output logic errCountClear,
  output logic errCountHold,
  output logic quietReceiver,
  output logic acceptAll,
  output logic copyAssembly
);
  cmoc_mon_if monBus ();

  logic [2:0] mode_r;
  logic [2:0] request_r;
  logic [15:0] cfgRegs_r [cmoc_pkg::CFG_COUNT];
  logic postEntryWait_r;
  logic transmit_request_flag_r;
  logic txAborted_r;
  logic wake_r;
  logic [15:0] cfgRdata_r;
  logic cfgRefused_r;
  logic busTxOut_r;
  logic busTxOe_n_r;
  logic txPinOwned_r;
  logic rxPinOwned_r;
  logic coreRx_r;
  logic txStart_r;
  logic txEnable_r;
  logic rxEnable_r;
  logic errCountClear_r;
  logic errCountHold_r;
  logic quietReceiver_r;
  logic acceptAll_r;
  logic copyAssembly_r;
  logic reqValid;
  logic changeOk;
  logic abortNow;
  logic startNow;
  logic cfgIndexOk;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic modeCodeValid(input logic [2:0] code);
    case (code)
      cmoc_pkg::MODE_NORMAL,
      cmoc_pkg::MODE_DISABLE,
      cmoc_pkg::MODE_LOOPBACK,
      cmoc_pkg::MODE_LISTEN_ONLY,
      cmoc_pkg::MODE_INIT,
      cmoc_pkg::MODE_LISTEN_ALL: modeCodeValid = 1'b1;
      default: modeCodeValid = 1'b0;
    endcase
  endfunction

  // Modes in which the module may drive frames.
  function automatic logic modeCanSend(input logic [2:0] code);
    modeCanSend = (code == cmoc_pkg::MODE_NORMAL) ||
                  (code == cmoc_pkg::MODE_LOOPBACK);
  endfunction

  // Modes in which the module is off the bus.
  function automatic logic modeOffline(input logic [2:0] code);
    modeOffline = (code == cmoc_pkg::MODE_INIT) ||
                  (code == cmoc_pkg::MODE_DISABLE);
  endfunction

  // ----------------------------------------------------------------
  // Bus monitor
  // ----------------------------------------------------------------
  assign monBus.rxPin = busRxPin;
  assign monBus.filterOn =
    cfgRegs_r[cmoc_pkg::CFG_TIMING2][cmoc_pkg::WAKE_FILT_BIT] &&
    (sleepMode || mode_r == cmoc_pkg::MODE_DISABLE);
  assign monBus.loopSel = (mode_r == cmoc_pkg::MODE_LOOPBACK);
  assign monBus.txInternal = coreTx;

  cmoc_bus_monitor monitor (
    .clk(clk),
    .reset(reset),
    .mon(monBus.mon)
  );

  // ----------------------------------------------------------------
  // Mode change
  // ----------------------------------------------------------------
  assign reqValid = modeCodeValid(request_r);
  // An offline module has no frame to disturb, so it changes at once.
  // Init additionally waits for any frame in flight to finish.
  always_comb begin
    changeOk = reqValid && (request_r != mode_r) &&
               (modeOffline(mode_r) || monBus.busIdle);
    if (request_r == cmoc_pkg::MODE_INIT && txActive) begin
      changeOk = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      request_r <= cmoc_pkg::MODE_RESET;
    end else begin
      request_r <= modeRequest;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_r <= cmoc_pkg::MODE_RESET;
    end else if (changeOk) begin
      mode_r <= request_r;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      controlWord <= 16'h0000;
    end else begin
      controlWord <= '0;
      controlWord[cmoc_pkg::REQ_LSB +: 3] <= request_r;
      controlWord[cmoc_pkg::STAT_LSB +: 3] <= mode_r;
    end
  end

  // ----------------------------------------------------------------
  // Configuration lock
  // ----------------------------------------------------------------
  assign cfgIndexOk = (cfgAddr < 3'(cmoc_pkg::CFG_COUNT));

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < cmoc_pkg::CFG_COUNT; i++) begin
        cfgRegs_r[i] <= cmoc_pkg::CFG_RESET;
      end
    end else if (cfgWe && cfgIndexOk && mode_r == cmoc_pkg::MODE_INIT) begin
      cfgRegs_r[cfgAddr] <= cfgWdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cfgRefused_r <= 1'b0;
      cfgRdata_r <= 16'h0000;
    end else begin
      cfgRefused_r <= cfgWe && (mode_r != cmoc_pkg::MODE_INIT);
      cfgRdata_r <= cfgIndexOk ? cfgRegs_r[cfgAddr] : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Transmit request, wait and abort
  // ----------------------------------------------------------------
  // After entry into a sending mode the first frame waits for idle.
  always_ff @(posedge clk) begin
    if (reset) begin
      postEntryWait_r <= 1'b1;
    end else if (changeOk && modeCanSend(request_r)) begin
      postEntryWait_r <= 1'b1;
    end else if (monBus.busIdle) begin
      postEntryWait_r <= 1'b0;
    end
  end

  assign abortNow = transmit_request_flag_r && postEntryWait_r && modeCanSend(mode_r) &&
                    (request_r == cmoc_pkg::MODE_DISABLE);
  assign startNow = transmit_request_flag_r && modeCanSend(mode_r) && !postEntryWait_r &&
                    !txActive && !abortNow;

  always_ff @(posedge clk) begin
    if (reset) begin
      transmit_request_flag_r <= 1'b0;
    end else if (txRequestSet) begin
      transmit_request_flag_r <= 1'b1;
    end else if (abortNow || startNow) begin
      transmit_request_flag_r <= 1'b0;
    end
  end

  // A new abort wins over a clear arriving in the same cycle.
  always_ff @(posedge clk) begin
    if (reset) begin
      txAborted_r <= 1'b0;
    end else if (abortNow) begin
      txAborted_r <= 1'b1;
    end else if (txAbortedClear) begin
      txAborted_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      txStart_r <= 1'b0;
    end else begin
      txStart_r <= startNow;
    end
  end

  // ----------------------------------------------------------------
  // Wake flag
  // ----------------------------------------------------------------
  // Wake and abort flags are never cleared by the mode logic itself.
  always_ff @(posedge clk) begin
    if (reset) begin
      wake_r <= 1'b0;
    end else if (monBus.activity && mode_r == cmoc_pkg::MODE_DISABLE) begin
      wake_r <= 1'b1;
    end else if (wakeClear) begin
      wake_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pins and mode qualifiers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      txPinOwned_r <= 1'b0;
      rxPinOwned_r <= 1'b0;
      busTxOut_r <= 1'b1;
      busTxOe_n_r <= 1'b1;
      coreRx_r <= 1'b1;
    end else begin
      // Only normal mode drives the pin; the rest hand it to port use.
      txPinOwned_r <= (mode_r == cmoc_pkg::MODE_NORMAL);
      busTxOe_n_r <= (mode_r != cmoc_pkg::MODE_NORMAL);
      busTxOut_r <= (mode_r == cmoc_pkg::MODE_NORMAL) ? coreTx : 1'b1;
      rxPinOwned_r <= (mode_r == cmoc_pkg::MODE_NORMAL) ||
                      (mode_r == cmoc_pkg::MODE_LISTEN_ONLY) ||
                      (mode_r == cmoc_pkg::MODE_LISTEN_ALL);
      coreRx_r <= modeOffline(mode_r) ? 1'b1 : monBus.rxLevel;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      txEnable_r <= 1'b0;
      rxEnable_r <= 1'b0;
      errCountClear_r <= 1'b1;
      errCountHold_r <= 1'b0;
      quietReceiver_r <= 1'b0;
      acceptAll_r <= 1'b0;
    end else begin
      txEnable_r <= modeCanSend(mode_r);
      rxEnable_r <= !modeOffline(mode_r);
      errCountClear_r <= (mode_r == cmoc_pkg::MODE_INIT);
      errCountHold_r <= (mode_r == cmoc_pkg::MODE_DISABLE) ||
                        (mode_r == cmoc_pkg::MODE_LISTEN_ONLY);
      quietReceiver_r <= (mode_r == cmoc_pkg::MODE_LISTEN_ONLY) ||
                         (mode_r == cmoc_pkg::MODE_LISTEN_ALL);
      acceptAll_r <= (mode_r == cmoc_pkg::MODE_LISTEN_ALL);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      copyAssembly_r <= 1'b0;
    end else begin
      copyAssembly_r <= frameError &&
                        (mode_r == cmoc_pkg::MODE_LISTEN_ALL);
    end
  end

  assign cfgRdata = cfgRdata_r;
  assign cfgRefused = cfgRefused_r;
  assign busTxOut = busTxOut_r;
  assign busTxOe_n = busTxOe_n_r;
  assign txPinOwned = txPinOwned_r;
  assign rxPinOwned = rxPinOwned_r;
  assign coreRx = coreRx_r;
  assign txRequestFlag = transmit_request_flag_r;
  assign txAbortedFlag = txAborted_r;
  assign txStart = txStart_r;
  assign wakeFlag = wake_r;
  assign txEnable = txEnable_r;
  assign rxEnable = rxEnable_r;
  assign errCountClear = errCountClear_r;
  assign errCountHold = errCountHold_r;
  assign quietReceiver = quietReceiver_r;
  assign acceptAll = acceptAll_r;
  assign copyAssembly = copyAssembly_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence sWaitingSend;
    transmit_request_flag_r && postEntryWait_r && modeCanSend(mode_r);
  endsequence

  sequence sDisableAsked;
    request_r == cmoc_pkg::MODE_DISABLE;
  endsequence

  a_mode_idle_gate: assert property (
    (mode_r != $past(mode_r)) |->
      $past(reqValid) && ($past(monBus.busIdle) || $past(modeOffline(mode_r))))
    else $error("mode changed without an acceptable moment");

  a_init_quiet: assert property (
    (mode_r == cmoc_pkg::MODE_INIT) ##1 (mode_r == cmoc_pkg::MODE_INIT) |->
      !txEnable_r && !rxEnable_r && errCountClear_r)
    else $error("init mode not quiet");

  a_cfg_locked: assert property (
    cfgWe && cfgIndexOk && mode_r != cmoc_pkg::MODE_INIT |=>
      cfgRefused_r && (cfgRegs_r[$past(cfgAddr)] == $past(cfgRegs_r[cfgAddr])))
    else $error("configuration written while on line");

  a_init_deferred: assert property (
    txActive && mode_r != cmoc_pkg::MODE_INIT |=>
      mode_r != cmoc_pkg::MODE_INIT)
    else $error("init entered during transmission");

  a_disable_hold: assert property (
    (mode_r == cmoc_pkg::MODE_DISABLE) ##1 (mode_r == cmoc_pkg::MODE_DISABLE)
      |-> errCountHold_r && !txEnable_r && busTxOe_n_r)
    else $error("disable mode not holding");

  a_wake_set: assert property (
    monBus.activity && mode_r == cmoc_pkg::MODE_DISABLE |=> wake_r)
    else $error("wake flag missed");

  a_abort_wait: assert property (
    sWaitingSend and sDisableAsked |=> txAborted_r && !txStart_r)
    else $error("pending frame not aborted");

  a_start_after_idle: assert property (
    startNow |-> !postEntryWait_r ##1
      txStart_r && (!transmit_request_flag_r || $past(txRequestSet)))
    else $error("frame started before idle wait");

  a_listen_all: assert property (
    frameError && mode_r == cmoc_pkg::MODE_LISTEN_ALL |=> copyAssembly_r)
    else $error("partial frame not copied");

  a_bad_code: assert property (
    !modeCodeValid(request_r) |=> $stable(mode_r))
    else $error("unassigned code changed mode");
endmodule

// ==== core/cmoc_pkg.sv ====
// Constants and mode encodings for the CAN operating mode controller.
package cmoc_pkg;
  // Mode request/status codes.
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_DISABLE = 3'h1;
  localparam logic [2:0] MODE_LOOPBACK = 3'h2;
  localparam logic [2:0] MODE_LISTEN_ONLY = 3'h3;
  localparam logic [2:0] MODE_INIT = 3'h4;
  localparam logic [2:0] MODE_LISTEN_ALL = 3'h7;
  localparam logic [2:0] MODE_RESET = MODE_INIT;

  // Field positions inside the control word readback.
  localparam int REQ_LSB = 8;
  localparam int STAT_LSB = 5;
  // Wake filter enable position in the second bit timing register.
  localparam int WAKE_FILT_BIT = 14;

  // Configuration register indices.
  localparam logic [2:0] CFG_CTRL = 3'h0;
  localparam logic [2:0] CFG_BAUD_INT = 3'h1;
  localparam logic [2:0] CFG_TIMING2 = 3'h2;
  localparam logic [2:0] CFG_TIMING1 = 3'h3;
  localparam logic [2:0] CFG_FILTER = 3'h4;
  localparam logic [2:0] CFG_MASK = 3'h5;
  localparam int CFG_COUNT = 6;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // Timing, with clock at 125 MHz.
  localparam int CLK_PERIOD_NS = 8;
  localparam int BIT_TIME_NS = 2000;
  localparam int FILT_TIME_NS = 1000;
  localparam int BIT_CYCLES =
    (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_CYCLES =
    (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] IDLE_BITS = 4'hb;
  localparam int CNT_W = 12;
endpackage

// ==== core/cmoc_mon_if.sv ====
// Signals between the mode controller and its bus line monitor.
`timescale 1ns/1ns
interface cmoc_mon_if;
  logic rxPin;
  logic filterOn;
  logic loopSel;
  logic txInternal;
  logic rxLevel;
  logic busIdle;
  logic activity;
  modport mon (
    input rxPin,
    input filterOn,
    input loopSel,
    input txInternal,
    output rxLevel,
    output busIdle,
    output activity
  );
  modport ctl (
    output rxPin,
    output filterOn,
    output loopSel,
    output txInternal,
    input rxLevel,
    input busIdle,
    input activity
  );
endinterface

// ==== core/cmoc_bus_monitor.sv ====
// Receive line synchroniser, wake filter and bus idle detector.
`timescale 1ns/1ns
module cmoc_bus_monitor (
  input wire logic clk,
  input wire logic reset,
  cmoc_mon_if.mon mon
);
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic pinLevel_r;
  logic filtered_r;
  logic prevLevel_r;
  logic busIdle_r;
  logic activity_r;
  logic [cmoc_pkg::CNT_W-1:0] filtCnt_r;
  logic [cmoc_pkg::CNT_W-1:0] bitCnt_r;
  logic [3:0] recBits_r;
  logic lineLevel;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      sync3_r <= 1'b1;
      pinLevel_r <= 1'b1;
    end else begin
      sync1_r <= mon.rxPin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) begin
        pinLevel_r <= sync3_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Wake filter
  // ----------------------------------------------------------------
  // Glitches shorter than the filter time never reach the wake logic.
  always_ff @(posedge clk) begin
    if (reset) begin
      filtered_r <= 1'b1;
      filtCnt_r <= '0;
    end else if (!mon.filterOn) begin
      filtered_r <= pinLevel_r;
      filtCnt_r <= '0;
    end else if (pinLevel_r == filtered_r) begin
      filtCnt_r <= '0;
    end else if (filtCnt_r ==
                 cmoc_pkg::CNT_W'(cmoc_pkg::FILT_CYCLES - 1)) begin
      filtered_r <= pinLevel_r;
      filtCnt_r <= '0;
    end else begin
      filtCnt_r <= filtCnt_r + 1'b1;
    end
  end

  // Loopback takes the internal transmit signal at the boundary.
  assign lineLevel = mon.loopSel ? mon.txInternal : filtered_r;

  // ----------------------------------------------------------------
  // Idle detector
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset || !lineLevel) begin
      bitCnt_r <= '0;
      recBits_r <= '0;
    end else if (bitCnt_r == cmoc_pkg::CNT_W'(cmoc_pkg::BIT_CYCLES - 1)) begin
      bitCnt_r <= '0;
      if (recBits_r != cmoc_pkg::IDLE_BITS) begin
        recBits_r <= recBits_r + 1'b1;
      end
    end else begin
      bitCnt_r <= bitCnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      busIdle_r <= 1'b0;
      prevLevel_r <= 1'b1;
      activity_r <= 1'b0;
    end else begin
      busIdle_r <= lineLevel && (recBits_r == cmoc_pkg::IDLE_BITS);
      prevLevel_r <= lineLevel;
      activity_r <= prevLevel_r && !lineLevel;
    end
  end

  assign mon.rxLevel = lineLevel;
  assign mon.busIdle = busIdle_r;
  assign mon.activity = activity_r;
endmodule

// ==== test/cmoc_bus_node.sv ====
// Behavioural model of the other nodes that share the CAN bus wire.
`timescale 1ns/1ns
module cmoc_bus_node (
  input wire logic clk,
  input wire logic talk,
  input wire logic glitch,
  input wire logic txOut,
  input wire logic txOe_n,
  output logic busLine
);
  logic level_r;
  int cnt_r;
  // Traffic flips the level once per bit time, starting dominant.
  always_ff @(posedge clk) begin
    if (!talk) begin
      cnt_r <= 0;
      level_r <= 1'b0;
    end else if (cnt_r == cmoc_pkg::BIT_CYCLES - 1) begin
      cnt_r <= 0;
      level_r <= !level_r;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
  // Wired-AND with a pull-up: silence reads recessive at once.
  assign busLine = (!talk | level_r) & (txOe_n | txOut) & !glitch;
endmodule

// ==== test/testbench.sv ====
// Self-checking bench of the CAN operating mode controller.
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] modeRequest = cmoc_pkg::MODE_INIT;
  logic cfgWe = 1'b0;
  logic [2:0] cfgAddr = 3'h0;
  logic [15:0] cfgWdata = 16'h0000;
  logic sleepMode = 1'b0;
  logic coreTx = 1'b1;
  logic txActive = 1'b0;
  logic frameError = 1'b0;
  logic txRequestSet = 1'b0;
  logic txAbortedClear = 1'b0;
  logic wakeClear = 1'b0;
  logic talk = 1'b0;
  logic glitch = 1'b0;
  logic [15:0] cfgRdata, controlWord;
  logic cfgRefused, busTxOut, busTxOe_n, txPinOwned, rxPinOwned, coreRx;
  logic txRequestFlag, txAbortedFlag, txStart, wakeFlag, txEnable;
  logic rxEnable, errCountClear, errCountHold, quietReceiver, acceptAll;
  logic copyAssembly, busLine, seen;
  logic [7:0] qual;
  logic [15:0] rd;
  int fail_count = 0;
  int cmp_count = 0;
  int waited;
  int starts = 0;
  assign qual = {txPinOwned, rxPinOwned, txEnable, rxEnable, errCountHold,
    quietReceiver, acceptAll, busTxOe_n};
  always #4 clk = ~clk;
  always @(posedge clk) if (txStart === 1'b1) starts++;
  cmoc_mode_ctrl cmoc_mode_ctrl_i (.clk(clk), .reset(reset),
    .modeRequest(modeRequest), .cfgWe(cfgWe), .cfgAddr(cfgAddr),
    .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .cfgRefused(cfgRefused),
    .controlWord(controlWord), .sleepMode(sleepMode), .busRxPin(busLine),
    .busTxOut(busTxOut), .busTxOe_n(busTxOe_n), .txPinOwned(txPinOwned),
    .rxPinOwned(rxPinOwned), .coreTx(coreTx), .coreRx(coreRx),
    .txActive(txActive), .frameError(frameError),
    .txRequestSet(txRequestSet), .txRequestFlag(txRequestFlag),
    .txAbortedFlag(txAbortedFlag), .txAbortedClear(txAbortedClear),
    .txStart(txStart), .wakeFlag(wakeFlag), .wakeClear(wakeClear),
    .txEnable(txEnable), .rxEnable(rxEnable),
    .errCountClear(errCountClear), .errCountHold(errCountHold),
    .quietReceiver(quietReceiver), .acceptAll(acceptAll),
    .copyAssembly(copyAssembly));
  cmoc_bus_node cmoc_bus_node_i (.clk(clk), .talk(talk), .glitch(glitch),
    .txOut(busTxOut), .txOe_n(busTxOe_n), .busLine(busLine));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic waitMode(input logic [2:0] m, input int lim);
    waited = 0;
    while (controlWord[7:5] !== m && waited < lim) begin
      cyc(1);
      #1;
      waited++;
    end
  endtask
  // Returns the refusal seen over two cycles and the readback after.
  task automatic cfgWrite(input logic [2:0] a, input logic [15:0] d);
    cfgAddr <= a;
    cfgWdata <= d;
    cfgWe <= 1'b1;
    cyc(1);
    cfgWe <= 1'b0;
    #1 seen = cfgRefused;
    cyc(1);
    #1 seen = seen | cfgRefused;
    cyc(1);
    #1 rd = cfgRdata;
    cyc(1);
  endtask
  // Stops traffic on a dominant bit, so the idle span starts here.
  task automatic dropTalk();
    waited = 0;
    while (busLine !== 1'b0 && waited < 600) begin
      cyc(1);
      #1;
      waited++;
    end
    cyc(1);
    talk <= 1'b0;
  endtask
  task automatic enterNormal();
    talk <= 1'b1;
    // Traffic first, so a stale idle span cannot end the entry wait.
    cyc(8);
    modeRequest <= cmoc_pkg::MODE_NORMAL;
    waitMode(cmoc_pkg::MODE_NORMAL, 5);
    cyc(3);
    #1 chk("normal status", 16'h0000, controlWord[7:5]);
    chk("normal pins", 16'h00f0, qual);
    cyc(1);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("control word", 16'h0480, controlWord);
    chk("count clear", 16'h0001, errCountClear);
    chk("init pins", 16'h0001, qual);
    chk("init rx", 16'h0001, coreRx);
  endtask
  task automatic t_config();
    for (int i = 0; i < 8; i++) begin
      cfgWrite(3'(i), 16'h4000 | 16'(i));
      chk("init refusal", 16'h0000, seen);
      chk("readback", i < 6 ? 16'h4000 | 16'(i) : 16'h0000, rd);
    end
  endtask
  task automatic t_txWait();
    enterNormal();
    cfgWrite(cmoc_pkg::CFG_MASK, 16'h0000);
    chk("online refusal", 16'h0001, seen);
    chk("locked reg", 16'h4005, rd);
    txRequestSet <= 1'b1;
    cyc(1);
    txRequestSet <= 1'b0;
    dropTalk();
    waited = 0;
    while (txStart !== 1'b1 && waited < 3200) begin
      cyc(1);
      #1;
      waited++;
    end
    seen = waited >= 2750 && waited <= 2800;
    chk("start wait", 16'h0001, seen);
    cyc(2);
    #1 chk("request cleared", 16'h0000, txRequestFlag);
  endtask
  task automatic t_abort();
    cyc(1);
    modeRequest <= cmoc_pkg::MODE_INIT;
    waitMode(cmoc_pkg::MODE_INIT, 3200);
    cyc(1);
    enterNormal();
    txRequestSet <= 1'b1;
    cyc(1);
    txRequestSet <= 1'b0;
    cyc(2);
    modeRequest <= cmoc_pkg::MODE_DISABLE;
    waited = starts;
    cyc(4);
    #1 chk("request flag", 16'h0000, txRequestFlag);
    chk("aborted flag", 16'h0001, txAbortedFlag);
    cyc(1000);
    #1 chk("busy bus mode", 16'h0000, controlWord[7:5]);
    chk("no start", 16'(waited), 16'(starts));
    dropTalk();
    waitMode(cmoc_pkg::MODE_DISABLE, 3200);
    seen = waited >= 2750 && waited <= 2800;
    chk("idle wait", 16'h0001, seen);
    cyc(3);
    #1 chk("disable pins", 16'h0009, qual);
    chk("flag kept", 16'h0001, txAbortedFlag);
    cyc(1);
    txAbortedClear <= 1'b1;
    cyc(1);
    txAbortedClear <= 1'b0;
    cyc(2);
    #1 chk("abort clear", 16'h0000, txAbortedFlag);
  endtask
  task automatic t_wake();
    cyc(1);
    glitch <= 1'b1;
    cyc(50);
    glitch <= 1'b0;
    cyc(200);
    #1 chk("short pulse", 16'h0000, wakeFlag);
    cyc(1);
    glitch <= 1'b1;
    cyc(300);
    glitch <= 1'b0;
    cyc(10);
    #1 chk("wake flag", 16'h0001, wakeFlag);
    cyc(1);
    wakeClear <= 1'b1;
    cyc(1);
    wakeClear <= 1'b0;
    cyc(2);
    #1 chk("wake clear", 16'h0000, wakeFlag);
  endtask
  task automatic t_modes();
    logic [2:0] codes [5] = '{3'h2, 3'h3, 3'h7, 3'h5, 3'h6};
    logic [2:0] modes [5] = '{3'h2, 3'h3, 3'h7, 3'h7, 3'h7};
    logic [7:0] pins [5] = '{8'h31, 8'h5d, 8'h57, 8'h57, 8'h57};
    for (int i = 0; i < 5; i++) begin
      cyc(1);
      modeRequest <= codes[i];
      if (codes[i] == modes[i]) waitMode(modes[i], 3200);
      else cyc(3200);
      cyc(3);
      #1 chk("mode", 16'(modes[i]), controlWord[7:5]);
      chk("mode pins", 16'(pins[i]), qual);
      cyc(1);
      frameError <= 1'b1;
      cyc(1);
      frameError <= 1'b0;
      seen = 1'b0;
      repeat (3) begin
        #1 seen = seen | copyAssembly;
        cyc(1);
      end
      chk("copy", 16'(modes[i] == 3'h7), seen);
      coreTx <= 1'b0;
      cyc(3);
      #1 chk("core rx", 16'(modes[i] != 3'h2), coreRx);
      chk("tx pin idle", 16'h0001, busTxOut);
      cyc(1);
      coreTx <= 1'b1;
      if (i == 1) begin
        sleepMode <= 1'b1;
        glitch <= 1'b1;
        cyc(40);
        #1 chk("sleep filter", 16'h0001, coreRx);
        cyc(1);
        sleepMode <= 1'b0;
        cyc(40);
        #1 chk("filter bypass", 16'h0000, coreRx);
        cyc(1);
        glitch <= 1'b0;
      end
    end
  endtask
  task automatic t_init();
    cyc(1);
    txActive <= 1'b1;
    modeRequest <= cmoc_pkg::MODE_INIT;
    cyc(3200);
    #1 chk("held off", 16'h0007, controlWord[7:5]);
    cyc(1);
    txActive <= 1'b0;
    waitMode(cmoc_pkg::MODE_INIT, 20);
    cyc(3);
    #1 chk("init entry", 16'h0004, controlWord[7:5]);
    chk("count clear", 16'h0001, errCountClear);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // The longest path needs about 23000 cycles.
  initial begin
    cyc(60000);
    fail_count++;
    complete_run();
  end
  initial begin
    cyc(10);
    reset <= 1'b0;
    cyc(3);
    #1 t_reset();
    cyc(1);
    t_config();
    t_txWait();
    t_abort();
    t_wake();
    t_modes();
    t_init();
    complete_run();
  end
endmodule
